// ---- rtl/csc_defines.svh ----
// Constants of the cycle-steal channel: sizes, offsets, field positions, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define CSC_NLVL       15            // Cycle-steal levels: 3 basic plus 12 optional
`define CSC_NTMR       3             // Interval timers
`define CSC_WORD_W     16            // Core data word width
`define CSC_PRE_W      16            // Width of the time-base prescaler
`define CSC_UNIT_W     11            // Width of a timer period counter

// ****************************************************************
// Timing
// ****************************************************************
`define CSC_CLK_NS     5             // REF_CLK period, 200 MHz
`define CSC_BASE_NS    125000        // Smallest time-base step, 0.125 ms
`define CSC_BASE_CLKS  (`CSC_BASE_NS / `CSC_CLK_NS)
`define CSC_MAX_CODE   4'h9          // Ten time-base choices, codes 0 to 9

// ****************************************************************
// Core words reserved for the timers
// ****************************************************************
`define CSC_TMR_ADR    16'h0004      // Timer 0 word; timers 1 and 2 follow

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CSC_OFS_PTR    4'h0          // Per-level table pointer
`define CSC_OFS_LIM    4'h4          // Per-level table end (chaining)
`define CSC_OFS_NXT    4'h8          // Per-level chained table start
`define CSC_OFS_CTL    4'hC          // Per-level control
`define CSC_ADR_TCTL   12'h100       // Timer run bits
`define CSC_ADR_TBASE  12'h104       // Timer time-base codes
`define CSC_ADR_STAT   12'h108       // Channel status

// ****************************************************************
// Field positions of the level control word
// ****************************************************************
`define CSC_CTL_DIR    0             // 1: core to device, 0: device to core
`define CSC_CTL_AUX    1             // Level steered to auxiliary storage
`define CSC_CTL_CHAIN  2             // Chaining on at table end

// ****************************************************************
// Reset values
// ****************************************************************
`define CSC_RST_WORD   16'h0000
`define CSC_RST_CTL    3'h0
`define CSC_RST_CODE   4'h0

`endif

// ---- rtl/csc_pkg.sv ----
// Types shared by the cycle-steal channel and its timer time base.
// Assumes csc_defines.svh on the include path.
`include "csc_defines.svh"

package csc_pkg;

  // ****************************************************************
  // Steal sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    CSC_IDLE,
    CSC_READ,
    CSC_LATCH,
    CSC_WRITE
  } csc_seq_t;

  // ****************************************************************
  // State of the channel, apart from the timer time base
  // ****************************************************************
  typedef struct packed {
    csc_seq_t                                  seq;       // Steal phase
    logic [3:0]                                lvl;       // Level being served
    logic                                      is_tmr;    // Steal belongs to a timer
    logic [1:0]                                tmr;       // Timer being served
    logic [`CSC_NLVL-1:0][`CSC_WORD_W-1:0]     ptr;       // Table pointers
    logic [`CSC_NLVL-1:0][`CSC_WORD_W-1:0]     lim;       // Table ends
    logic [`CSC_NLVL-1:0][`CSC_WORD_W-1:0]     nxt;       // Chained starts
    logic [`CSC_NLVL-1:0][2:0]                 ctl;       // Level controls
    logic [`CSC_NTMR-1:0]                      run;       // Timer run bits
    logic [`CSC_NTMR-1:0][3:0]                 code;      // Time-base codes
    logic [`CSC_NTMR-1:0]                      pend;      // Timer increments owed
    logic                                      mem_req;   // Core access strobe
    logic                                      mem_we;    // Core write
    logic                                      mem_aux;   // Auxiliary storage select
    logic [`CSC_WORD_W-1:0]                    mem_adr;   // Core address
    logic [`CSC_WORD_W-1:0]                    mem_wdat;  // Core write data
    logic                                      hold;      // Processor held
    logic [`CSC_NLVL-1:0]                      grant;     // Level served
    logic [`CSC_WORD_W-1:0]                    dev_rdat;  // Word for the device
    logic                                      irq;       // Timer wrap request
    logic                                      ack;       // Bus acknowledge
    logic [31:0]                               rdat;      // Bus read data
  } csc_state_t;

  // ****************************************************************
  // State of the timer time base
  // ****************************************************************
  typedef struct packed {
    logic [`CSC_PRE_W-1:0]                     pre;       // Prescaler
    logic [`CSC_NTMR-1:0][`CSC_UNIT_W-1:0]     cnt;       // Base steps in period
    logic [`CSC_NTMR-1:0]                      tick;      // Period completed
  } csc_tb_state_t;

endpackage

// ---- rtl/csc_timebase.sv ----
// Time base of the three interval timers: one prescaler, one period counter per timer.
// Assumes the channel clears nothing here; it only reads the one-cycle tick pulses.
`timescale 1ns/1ps
`include "csc_defines.svh"

module csc_timebase #(
  parameter int BASE_CLKS = `CSC_BASE_CLKS,  // Clocks in one 0.125 ms step
  parameter bit MODEL2    = 1'b0             // 0: first model, 1: second model
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [`CSC_NTMR-1:0]          run,
  input  wire logic [`CSC_NTMR-1:0][3:0]     code,
  output logic      [`CSC_NTMR-1:0]          tick
);

  csc_pkg::csc_tb_state_t  tb_r;    // Registered state
  csc_pkg::csc_tb_state_t  tb_nxt;  // Next state
  logic                    step;    // One 0.125 ms step done
  logic [3:0]              c;       // Clamped code
  logic [`CSC_UNIT_W-1:0]  units;   // Period in steps

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    tb_nxt = tb_r;
    c      = 4'h0;
    units  = '0;
    // Prescaler free-runs so all timers share one phase
    step = (tb_r.pre == `CSC_PRE_W'(BASE_CLKS - 1));
    tb_nxt.pre = step ? '0 : tb_r.pre + `CSC_PRE_W'(1);
    for (int i = 0; i < `CSC_NTMR; i++) begin
      // Unused codes above nine fall back to the longest period
      c = (code[i] > `CSC_MAX_CODE) ? `CSC_MAX_CODE : code[i];
      // Period choices of the two models
      units = MODEL2 ? (`CSC_UNIT_W'(1) << c) : (`CSC_UNIT_W'(2) << c);
      tb_nxt.tick[i] = 1'b0;
      if (!run[i]) begin
        // Stopped timer restarts its step count from zero when run again
        tb_nxt.cnt[i] = '0;
      end else if (step) begin
        if (tb_r.cnt[i] + `CSC_UNIT_W'(1) == units) begin
          tb_nxt.cnt[i]  = '0;
          tb_nxt.tick[i] = 1'b1;
        end else begin
          tb_nxt.cnt[i] = tb_r.cnt[i] + `CSC_UNIT_W'(1);
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_r <= '0;
    end else begin
      tb_r <= tb_nxt;
    end
  end

  assign tick = tb_r.tick;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_stop_quiet;
    @(posedge clk) disable iff (!rst_b)
      !run[0] |=> !tick[0];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("stopped timer ticked");

endmodule

// ---- rtl/csc_channel.sv ----
// Cycle-steal data channel with interval timers, top level.
// Assumes device adapters and core storage run on REF_CLK; registers over classic Wishbone.
//
// Notes on behaviour
// - Fifteen prioritized levels, one device per level
// - Each steal delays processor one machine cycle
// - Initialization loads level table pointer
// - Highest active level wins at cycle end
// - Pointer addresses core; one word moves
// - Pointer advances after every transfer
// - Storage returns to processor, no program help
// - Chaining continues or repeats tables
// - Auxiliary-initialized level keeps using auxiliary storage
// - Timer words at three consecutive core words
// - First model time bases 0.25 to 128 ms
// - Second model time bases 0.125 to 64 ms
// - Program starts and stops timers
// - Running timer incremented by steal each period
// - Sixteen-bit timer word wraps to zero
// - Zero timer word requests interrupt
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "csc_defines.svh"

module csc_channel #(
  parameter int BASE_CLKS = `CSC_BASE_CLKS,  // Clocks in one 0.125 ms step
  parameter bit MODEL2    = 1'b0             // Time-base model select
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_B,
  // Wishbone slave
  input  wire logic                       WB_CYC_I,
  input  wire logic                       WB_STB_I,
  input  wire logic                       WB_WE_I,
  input  wire logic [11:0]                WB_ADR_I,
  input  wire logic [3:0]                 WB_SEL_I,
  input  wire logic [31:0]                WB_DAT_I,
  output logic      [31:0]                WB_DAT_O,
  output logic                            WB_ACK_O,
  // Processor side
  input  wire logic                       CYCLE_END,
  output logic                            CPU_HOLD,
  // Core storage
  output logic                            MEM_REQ,
  output logic                            MEM_WE,
  output logic                            MEM_AUX,
  output logic      [`CSC_WORD_W-1:0]     MEM_ADR,
  output logic      [`CSC_WORD_W-1:0]     MEM_WDATA,
  input  wire logic [`CSC_WORD_W-1:0]     MEM_RDATA,
  // Device adapters
  input  wire logic [`CSC_NLVL-1:0]       CS_REQ,
  output logic      [`CSC_NLVL-1:0]       CS_GRANT,
  input  wire logic [`CSC_WORD_W-1:0]     DEV_WDATA,
  output logic      [`CSC_WORD_W-1:0]     DEV_RDATA,
  // Timer interrupt request
  output logic                            TIMER_IRQ
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  csc_pkg::csc_state_t     st_r;      // Registered state
  csc_pkg::csc_state_t     st_nxt;    // Next state
  logic [`CSC_NTMR-1:0]    tick;      // Timer periods completed
  logic [`CSC_NTMR-1:0]    tmr_clr;   // Timer increment served
  logic                    bus_on;    // Access on the bus, CYC and STB both high
  logic                    bus_wr;    // Write takes effect now
  logic                    in_lvl;    // Address inside level window
  logic [3:0]              a_lvl;     // Addressed level
  logic [3:0]              win;       // Winning level
  logic [1:0]              twin;      // Winning timer
  logic [`CSC_WORD_W-1:0]  adv;       // Advanced pointer
  logic [`CSC_WORD_W-1:0]  wdat16;    // Low half of bus write data
  logic [31:0]             rd_val;    // Read mux

  // ****************************************************************
  // Timer time base
  // ****************************************************************
  csc_timebase #(
    .BASE_CLKS (BASE_CLKS),
    .MODEL2    (MODEL2)
  ) u_timebase (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .run   (st_r.run),
    .code  (st_r.code),
    .tick  (tick)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Writes land at the edge that ends the ack cycle, matching the master
  assign bus_on = WB_CYC_I & WB_STB_I;
  assign bus_wr = bus_on & WB_WE_I & st_r.ack;
  assign a_lvl  = WB_ADR_I[7:4];
  assign in_lvl = (WB_ADR_I[11:8] == 4'h0) && (a_lvl < 4'(`CSC_NLVL));
  // Byte lanes above the 16-bit words are ignored
  assign wdat16 = {WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00,
                   WB_SEL_I[0] ? WB_DAT_I[7:0]  : 8'h00};

  // ****************************************************************
  // Next state: steal sequencer, timers and register file
  // ****************************************************************
  always_comb begin
    st_nxt  = st_r;
    tmr_clr = '0;
    win     = 4'h0;
    twin    = 2'h0;
    adv     = st_r.ptr[st_r.lvl] + `CSC_WORD_W'(1);
    rd_val  = 32'h0000_0000;
    st_nxt.grant = '0;
    st_nxt.irq   = 1'b0;
    // Priority: lowest level number first, timers above all levels
    for (int i = `CSC_NLVL - 1; i >= 0; i--) begin
      if (CS_REQ[i]) begin
        win = 4'(i);
      end
    end
    for (int j = `CSC_NTMR - 1; j >= 0; j--) begin
      if (st_r.pend[j]) begin
        twin = 2'(j);
      end
    end
    case (st_r.seq)
      csc_pkg::CSC_IDLE: begin
        // Steal only at a machine-cycle boundary
        if (CYCLE_END && ((|st_r.pend) || (|CS_REQ))) begin
          st_nxt.seq     = csc_pkg::CSC_READ;
          st_nxt.hold    = 1'b1;
          st_nxt.mem_req = 1'b1;
          st_nxt.mem_we  = 1'b0;
          if (|st_r.pend) begin
            // Timer words sit at consecutive reserved core words
            st_nxt.is_tmr  = 1'b1;
            st_nxt.tmr     = twin;
            st_nxt.mem_aux = 1'b0;
            st_nxt.mem_adr = `CSC_TMR_ADR + `CSC_WORD_W'(twin);
          end else begin
            // Winning pointer addresses core
            st_nxt.is_tmr  = 1'b0;
            st_nxt.lvl     = win;
            st_nxt.mem_aux = st_r.ctl[win][`CSC_CTL_AUX];
            st_nxt.mem_adr = st_r.ptr[win];
          end
        end
      end
      csc_pkg::CSC_READ: begin
        // Core answers on the next cycle
        st_nxt.seq     = csc_pkg::CSC_LATCH;
        st_nxt.mem_req = 1'b0;
      end
      csc_pkg::CSC_LATCH: begin
        st_nxt.seq     = csc_pkg::CSC_WRITE;
        st_nxt.mem_req = 1'b1;
        st_nxt.mem_we  = 1'b1;
        if (st_r.is_tmr) begin
          // Add one; all ones wraps to zero
          st_nxt.mem_wdat = MEM_RDATA + `CSC_WORD_W'(1);
          st_nxt.irq      = (MEM_RDATA == 16'hFFFF);
          tmr_clr[st_r.tmr] = 1'b1;
        end else begin
          if (st_r.ctl[st_r.lvl][`CSC_CTL_DIR]) begin
            // Core to device: read word restored, copy handed over
            st_nxt.mem_wdat = MEM_RDATA;
            st_nxt.dev_rdat = MEM_RDATA;
          end else begin
            st_nxt.mem_wdat = DEV_WDATA;
          end
          // Grant stands while the write is on, device drops its request
          st_nxt.grant[st_r.lvl] = 1'b1;
        end
      end
      csc_pkg::CSC_WRITE: begin
        // Storage back to the processor
        st_nxt.seq     = csc_pkg::CSC_IDLE;
        st_nxt.hold    = 1'b0;
        st_nxt.mem_req = 1'b0;
        st_nxt.mem_we  = 1'b0;
        if (!st_r.is_tmr) begin
          // Chain to the next table, or advance
          if (st_r.ctl[st_r.lvl][`CSC_CTL_CHAIN] && (adv == st_r.lim[st_r.lvl])) begin
            st_nxt.ptr[st_r.lvl] = st_r.nxt[st_r.lvl];
          end else begin
            st_nxt.ptr[st_r.lvl] = adv;
          end
        end
      end
      default: begin
        st_nxt.seq = csc_pkg::CSC_IDLE;
      end
    endcase
    // A period ending as its increment is served is kept
    st_nxt.pend = (st_r.pend & ~tmr_clr) | (tick & st_r.run);
    // Register writes; initialization overrides an advance in the same cycle
    if (bus_wr && in_lvl) begin
      case (WB_ADR_I[3:0])
        `CSC_OFS_PTR: st_nxt.ptr[a_lvl] = wdat16;
        `CSC_OFS_LIM: st_nxt.lim[a_lvl] = wdat16;
        `CSC_OFS_NXT: st_nxt.nxt[a_lvl] = wdat16;
        `CSC_OFS_CTL: st_nxt.ctl[a_lvl] = wdat16[2:0];
        default: begin
          // Holes in the level window ignore writes
        end
      endcase
    end else if (bus_wr && (WB_ADR_I == `CSC_ADR_TCTL)) begin
      st_nxt.run = wdat16[`CSC_NTMR-1:0];
    end else if (bus_wr && (WB_ADR_I == `CSC_ADR_TBASE)) begin
      st_nxt.code = wdat16[11:0];
    end
    // Read mux; unmapped addresses read zero
    if (in_lvl) begin
      case (WB_ADR_I[3:0])
        `CSC_OFS_PTR: rd_val = {16'h0000, st_r.ptr[a_lvl]};
        `CSC_OFS_LIM: rd_val = {16'h0000, st_r.lim[a_lvl]};
        `CSC_OFS_NXT: rd_val = {16'h0000, st_r.nxt[a_lvl]};
        `CSC_OFS_CTL: rd_val = {29'h0000_0000, st_r.ctl[a_lvl]};
        default:      rd_val = 32'h0000_0000;
      endcase
    end else if (WB_ADR_I == `CSC_ADR_TCTL) begin
      rd_val = {29'h0000_0000, st_r.run};
    end else if (WB_ADR_I == `CSC_ADR_TBASE) begin
      rd_val = {20'h0_0000, st_r.code};
    end else if (WB_ADR_I == `CSC_ADR_STAT) begin
      rd_val = {20'h0_0000, st_r.is_tmr, st_r.pend, st_r.lvl, 3'h0, st_r.hold};
    end
    // One-cycle ack, then a gap before the next access
    st_nxt.ack  = bus_on & ~st_r.ack;
    st_nxt.rdat = (bus_on & ~st_r.ack) ? rd_val : st_r.rdat;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign WB_DAT_O  = st_r.rdat;
  assign WB_ACK_O  = st_r.ack;
  assign CPU_HOLD  = st_r.hold;
  assign MEM_REQ   = st_r.mem_req;
  assign MEM_WE    = st_r.mem_we;
  assign MEM_AUX   = st_r.mem_aux;
  assign MEM_ADR   = st_r.mem_adr;
  assign MEM_WDATA = st_r.mem_wdat;
  assign CS_GRANT  = st_r.grant;
  assign DEV_RDATA = st_r.dev_rdat;
  assign TIMER_IRQ = st_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  property p_one_grant;
    $onehot0(CS_GRANT);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two levels granted");

  property p_hold_len;
    $rose(CPU_HOLD) |-> CPU_HOLD[*3] ##1 !CPU_HOLD;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("steal not three clocks");

  property p_init;
    bus_wr && in_lvl && (WB_ADR_I[3:0] == `CSC_OFS_PTR) && (st_r.seq != csc_pkg::CSC_WRITE)
      |=> st_r.ptr[$past(a_lvl)] == $past(wdat16);
  endproperty
  a_init: assert property (p_init) else $error("pointer not loaded");

  property p_start;
    (st_r.seq == csc_pkg::CSC_IDLE) && CYCLE_END && (|CS_REQ) |=> MEM_REQ && !MEM_WE ##2 MEM_WE;
  endproperty
  a_start: assert property (p_start) else $error("request not stolen");

  property p_addr;
    MEM_REQ && !MEM_WE && !st_r.is_tmr |-> MEM_ADR == st_r.ptr[st_r.lvl];
  endproperty
  a_addr: assert property (p_addr) else $error("wrong table address");

  property p_adv;
    (st_r.seq == csc_pkg::CSC_WRITE) && !st_r.is_tmr && !bus_wr
      && !st_r.ctl[st_r.lvl][`CSC_CTL_CHAIN]
      |=> st_r.ptr[$past(st_r.lvl)] == $past(adv);
  endproperty
  a_adv: assert property (p_adv) else $error("pointer not advanced");

  // Chained table end must load the chained start, not the advance
  property p_chain;
    (st_r.seq == csc_pkg::CSC_WRITE) && !st_r.is_tmr && !bus_wr
      && st_r.ctl[st_r.lvl][`CSC_CTL_CHAIN] && (adv == st_r.lim[st_r.lvl])
      |=> st_r.ptr[$past(st_r.lvl)] == $past(st_r.nxt[st_r.lvl]);
  endproperty
  a_chain: assert property (p_chain) else $error("table not chained");

  property p_release;
    |CS_GRANT |=> !CPU_HOLD && !MEM_REQ && (CS_GRANT == '0);
  endproperty
  a_release: assert property (p_release) else $error("storage not returned");

  property p_aux;
    MEM_REQ && !st_r.is_tmr |-> MEM_AUX == st_r.ctl[st_r.lvl][`CSC_CTL_AUX];
  endproperty
  a_aux: assert property (p_aux) else $error("storage select wrong");

  property p_tmr_adr;
    MEM_REQ && st_r.is_tmr |-> (MEM_ADR == `CSC_TMR_ADR + `CSC_WORD_W'(st_r.tmr)) && !MEM_AUX;
  endproperty
  a_tmr_adr: assert property (p_tmr_adr) else $error("timer word address wrong");

  property p_inc;
    (st_r.seq == csc_pkg::CSC_LATCH) && st_r.is_tmr
      |=> MEM_WE && (MEM_WDATA == $past(MEM_RDATA) + `CSC_WORD_W'(1));
  endproperty
  a_inc: assert property (p_inc) else $error("timer not incremented");

  property p_irq;
    TIMER_IRQ |-> MEM_WE && st_r.is_tmr && (MEM_WDATA == 16'h0000);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without wrap");

  c_timer: cover property (TIMER_IRQ);
  c_aux: cover property (MEM_REQ && MEM_AUX);
  c_dev_out: cover property (|CS_GRANT && st_r.ctl[st_r.lvl][`CSC_CTL_DIR]);
  c_chain: cover property ((st_r.seq == csc_pkg::CSC_WRITE) && !st_r.is_tmr
                           && st_r.ctl[st_r.lvl][`CSC_CTL_CHAIN]
                           && (adv == st_r.lim[st_r.lvl]));

endmodule

// ---- verification/csc_dev_model.sv ----
// Device adapter model: one request line per level.
// Assumes grant is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module csc_dev_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic go,     // One word ready
  input  wire logic grant,  // Level served
  input  wire logic last,   // Word handed over ends the record
  output logic      req     // Steal request
);
  logic done;  // Record finished, no more requests
  // Held until served, so no word is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req  <= 1'b0;
      done <= 1'b0;
    end else if (grant) begin
      req  <= 1'b0;
      done <= done | last;  // Punch stops on an end-marked word
    end else if (go && !done) begin
      req <= 1'b1;
    end
  end
endmodule

// ---- verification/tb.sv ----
// Bench of the cycle-steal channel: bus master, core model, adapters.
// Assumes BASE_CLKS of 4 so timer periods stay short.
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, cend = 0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, rd, wb_do, seed = 32'hB1DC;
  logic        ack, hold, mem_req, mem_we, mem_aux, irq;
  logic [15:0] mem_adr, mem_wd, mem_rd = 16'h0, dev_wd = 16'h0, dev_rd;
  logic [14:0] req, grant, go = 15'h0;
  logic [16:0] q[$];  // Expected {aux, address} of each read steal
  logic [3:0]  sel = 4'h3;         // Byte lanes
  logic [14:0] dirs = 15'h0020;    // Levels set core to device
  logic        end_rec = 0, rd_seen = 0;
  logic [15:0] core_word, dev_word;  // Words the design latched
  int          miscompares = 0, samples_checked = 0, cycles = 0;

  csc_channel #(.BASE_CLKS(4)) dut (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(wb_do), .WB_ACK_O(ack), .CYCLE_END(cend), .CPU_HOLD(hold),
    .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_AUX(mem_aux), .MEM_ADR(mem_adr),
    .MEM_WDATA(mem_wd), .MEM_RDATA(mem_rd), .CS_REQ(req), .CS_GRANT(grant),
    .DEV_WDATA(dev_wd), .DEV_RDATA(dev_rd), .TIMER_IRQ(irq));
  for (genvar i = 0; i < 15; i++) begin : g_dev
    csc_dev_model m (.clk(clk), .rst_b(rst_b), .go(go[i]), .grant(grant[i]),
      .last(dev_rd[12] & dirs[i]), .req(req[i]));
  end

  initial forever #2.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task chk(input string n, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = wb_do;
    cyc <= 0;
    stb <= 0;
  endtask

  // Pulse ready lines, then wait for the notes to drain
  task fire(input logic [14:0] m);
    @(posedge clk);
    go <= m;
    @(posedge clk);
    go <= 15'h0;
    repeat (400) if (q.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task test_done;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Cycle boundaries, random core and device data, timeout
  // ****************************************************************
  always @(posedge clk) begin
    seed = xs(seed);
    cycles <= cycles + 1;
    cend <= (cycles[1:0] == 2'h3);
    // Timer word all ones, so every increment wraps
    mem_rd <= (mem_adr == 16'h0004) ? 16'hFFFF :
              {seed[15:13], end_rec, seed[11:0]};
    dev_wd <= seed[31:16];
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // Watcher: read steals in order, timer wraps
  always @(posedge clk) begin
    rd_seen <= rst_b && mem_req && !mem_we;
    if (rd_seen) begin
      core_word = mem_rd;
      dev_word  = dev_wd;
    end
    if (rst_b && mem_req && !mem_we && q.size() > 0)
      chk("mem_adr", q.pop_front(), {mem_aux, mem_adr});
    else if (rst_b && mem_req && !mem_we && mem_adr != 16'h0004)
      chk("extra_steal", 17'h1FFFF, {mem_aux, mem_adr});
    if (rst_b && mem_req && mem_we && |grant) begin
      chk("wr_data", |(grant & dirs) ? core_word : dev_word, mem_wd);
      chk("hold", 17'h1, {16'h0, hold});
      if (|(grant & dirs))
        chk("dev_rd", core_word, dev_rd);
    end
    if (rst_b && mem_req && mem_we && mem_adr == 16'h0004) begin
      chk("tmr_word", 17'h0, {1'b0, mem_wd});
      chk("tmr_irq", 17'h1, {16'h0, irq});
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    wb(1, 12'h020, 32'h0100);
    wb(1, 12'h050, 32'h0200);
    wb(1, 12'h054, 32'h0201);
    wb(1, 12'h058, 32'h0200);
    wb(1, 12'h05C, 32'h5);
    wb(0, 12'h020, 32'h0);
    chk("ptr2", 17'h0100, rd[16:0]);
    wb(0, 12'h200, 32'h0);
    chk("unmapped", 17'h0, rd[16:0]);
    sel <= 4'h1;
    wb(1, 12'h030, 32'hABCD);
    sel <= 4'h3;
    wb(0, 12'h030, 32'h0);
    chk("lane", 17'h00CD, rd[16:0]);
    q.push_back(17'h00100);
    q.push_back(17'h00200);
    fire(15'h0024);
    q.push_back(17'h00101);
    q.push_back(17'h00200);
    fire(15'h0024);
    wb(1, 12'h02C, 32'h2);
    q.push_back(17'h10102);
    fire(15'h0004);
    q.push_back(17'h10103);
    fire(15'h0004);
    wb(1, 12'h104, 32'h0);
    wb(1, 12'h100, 32'h1);
    q.push_back(17'h00004);
    q.push_back(17'h00004);
    fire(15'h0);
    wb(1, 12'h100, 32'h0);
    for (int i = 0; i < 15; i++)
      wb(1, 12'(i * 16), 32'h0300 + i);
    for (int i = 0; i < 15; i++)
      q.push_back({i == 2, 16'h0300 + 16'(i)});
    fire(15'h7FFF);
    end_rec <= 1'b1;
    q.push_back(17'h00306);
    fire(15'h0020);
    fire(15'h0020);
    chk("notes_left", 17'h0, 17'(q.size()));
    test_done();
  end
endmodule
